// ### fbreg_asserts.sv
// checker of the buffer sizing and pause watermark register bank
// bound to fbreg_top; sees its ports only, one pclk domain
`timescale 1ns/1ps
module fbreg_asserts #(
    parameter int FILL_W = 16,
    parameter int TOL_W  = 12
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        rx_frame_store,
    input wire logic [15:0] rx_frame_len,
    input wire logic [7:0]  rx_frame_extra,
    input wire logic        rx_drain,
    input wire logic        rx_buffer_flush,
    input wire logic        latency_idle_state,
    input wire logic [1:0]  link_speed,
    input wire logic [13:0] rx_buffer_end_addr,
    input wire logic [12:0] tx_buffer_end_addr,
    input wire logic        pause_request,
    input wire logic [15:0] rx_buffer_fill_bytes,
    input wire logic [11:0] idle_tolerance,
    input wire logic        idle_tolerance_valid
);
    // ==========================================
    // shadow of watermarks and pause enable
    logic [6:0]  on_q;
    logic [6:0]  off_q;
    logic        en_q;
    logic        wr_hit;
    logic [6:0]  units;
    logic [17:0] sum;
    logic [15:0] sum_sat;
    logic        tol_sel;
    assign wr_hit  = psel && penable && pready && pwrite;
    assign units   = rx_buffer_fill_bytes[15:9];
    assign sum     = {2'b00, rx_buffer_fill_bytes} + {1'b0, ({1'b0, rx_frame_len} + 17'h0_0003)
                     & 17'h1_fffc} + {10'h000, rx_frame_extra};
    assign sum_sat = (sum > 18'h0_ffff) ? 16'hffff : sum[15:0];
    assign tol_sel = latency_idle_state && (link_speed == 2'b01 || link_speed == 2'b10);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q  <= 7'h00;
            off_q <= 7'h00;
            en_q  <= 1'b0;
        end else if (wr_hit) begin
            if (paddr == fbreg_pkg::WMARK_OFS && pstrb[0]) on_q <= pwdata[6:0];
            if (paddr == fbreg_pkg::WMARK_OFS && pstrb[1]) off_q <= pwdata[14:8];
            if (paddr == fbreg_pkg::PAUSE_OFS && pstrb[0]) en_q <= pwdata[0];
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rx_end_tail: assert property ($past(presetn) |-> rx_buffer_end_addr[6:0] == 7'h7f)
        else $error("rx end address tail wrong");
    a_tx_end_tail: assert property ($past(presetn) |-> tx_buffer_end_addr[6:0] == 7'h7f)
        else $error("tx end address tail wrong");
    a_pause_on: assert property (en_q && units >= on_q |=> pause_request)
        else $error("pause not raised");
    a_pause_off: assert property (en_q && units <= off_q && units < on_q |=> !pause_request)
        else $error("pause not dropped");
    a_pause_hold: assert property (en_q && units > off_q && units < on_q
        |=> $stable(pause_request))
        else $error("pause changed between levels");
    a_pause_gate: assert property (!en_q |=> !pause_request)
        else $error("pause without enable");
    a_fill_store: assert property (rx_frame_store && !rx_drain && !rx_buffer_flush
        |=> rx_buffer_fill_bytes == $past(sum_sat))
        else $error("fill after store wrong");
    a_fill_flush: assert property (rx_buffer_flush |=> rx_buffer_fill_bytes == 16'h0000)
        else $error("fill not cleared");
    a_tol_valid: assert property (1'b1 |=> idle_tolerance_valid == $past(tol_sel))
        else $error("tolerance valid wrong");
    a_tol_zero: assert property (!idle_tolerance_valid |-> idle_tolerance == 12'h000)
        else $error("tolerance not zero");
    a_bad_addr: assert property (psel && penable && !pready && paddr == 12'h0e4
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
endmodule

bind fbreg_top fbreg_asserts #(.FILL_W(FILL_W), .TOL_W(TOL_W)) u_fbreg_chk (.*);

// ### fbreg_pkg.sv
// constants of the buffer sizing, pause watermark and
// latency tolerance register bank; no other dependencies
// Behaviour
// - each buffer end address in dwords is the end field times 128 plus 127.
// - the receive end field is read/write in bits 6:0 and resets to 17h (12 KB).
// - the transmit end field is read/write in bits 5:0 and resets to 17h (12 KB).
// - both pause watermarks count receive buffer fill in 512-byte units.
// - pause turns on when fill/512 is at or above the on watermark in bits 6:0.
// - pause turns off when fill/512 is at or below the off watermark in bits 14:8 and below the on watermark.
// - receive path status gives total fill in 31:16 and upstream buffer fill in 15:0.
// - transmit path status gives total fill in 31:16 and upstream (usb side) buffer fill in 15:0.
// - in the latency idle state bits 27:16 serve gigabit links, bits 11:0 100 Mbps.
// - tolerance defaults come from eeprom, else from otp, else zero.
// - usb reset or light reset restores tolerance fields to the last loaded image.
// - receive fill grows per frame by its dword-rounded length plus extra bytes.
package fbreg_pkg;
    // =========================================
    // register offsets
    localparam logic [11:0] RX_END_OFS   = 12'h0_0c8;
    localparam logic [11:0] TX_END_OFS   = 12'h0_0cc;
    localparam logic [11:0] WMARK_OFS    = 12'h0_0d0;
    localparam logic [11:0] RX_OCC_OFS   = 12'h0_0d4;
    localparam logic [11:0] TX_OCC_OFS   = 12'h0_0d8;
    localparam logic [11:0] PAUSE_OFS    = 12'h0_0dc;
    localparam logic [11:0] IDLE_TOL_OFS = 12'h0_0e0;
    // =========================================
    // field positions and widths
    localparam int RX_END_W   = 7;
    localparam int TX_END_W   = 6;
    localparam int WM_W       = 7;
    localparam int WM_ON_LSB  = 0;
    localparam int WM_OFF_LSB = 8;
    localparam int OCC_W      = 16;
    localparam int TOTAL_LSB  = 16;
    localparam int TOL_W      = 12;
    localparam int TOL_GIG_LSB  = 16;
    localparam int TOL_FAST_LSB = 0;
    localparam int PAUSE_EN_BIT = 0;
    localparam int PAUSE_ST_BIT = 1;
    localparam int WM_UNIT_SHIFT = 9;
    // =========================================
    // end address arithmetic
    localparam int END_SHIFT = 7;
    localparam logic [6:0] END_TAIL = 7'h7f;
    // =========================================
    // reset values
    localparam logic [6:0] RX_END_RST = 7'h17;
    localparam logic [5:0] TX_END_RST = 6'h17;
    localparam logic [6:0] WM_RST     = 7'h00;
    localparam logic [11:0] TOL_RST   = 12'h000;
    // =========================================
    // link speeds
    typedef enum logic [1:0] {
        FBREG_SPD_10   = 2'b00,
        FBREG_SPD_100  = 2'b01,
        FBREG_SPD_1000 = 2'b10
    } fbreg_speed_t;
endpackage

// ### fbreg_top.sv
// buffer sizing, pause watermark, occupancy and idle
// latency tolerance registers behind an apb4 slave;
// all inputs synchronous to pclk, pulses one cycle wide
`timescale 1ns/1ps
module fbreg_top #(
    parameter int FILL_W = 16,
    parameter int TOL_W  = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        rx_frame_store,
    input  wire logic [15:0] rx_frame_len,
    input  wire logic [7:0]  rx_frame_extra,
    input  wire logic        rx_drain,
    input  wire logic [15:0] rx_drain_bytes,
    input  wire logic        rx_buffer_flush,
    input  wire logic [15:0] usb_side_rx_fill,
    input  wire logic [15:0] usb_side_tx_fill,
    input  wire logic [15:0] tx_buffer_fill_bytes,
    input  wire logic        latency_idle_state,
    input  wire logic [1:0]  link_speed,
    input  wire logic        eeprom_tol_valid,
    input  wire logic [11:0] eeprom_tol_gigabit,
    input  wire logic [11:0] eeprom_tol_fast,
    input  wire logic        otp_tol_valid,
    input  wire logic [11:0] otp_tol_gigabit,
    input  wire logic [11:0] otp_tol_fast,
    input  wire logic        nvm_load,
    input  wire logic        usb_reset,
    input  wire logic        light_soft_reset,
    output logic [13:0]      rx_buffer_end_addr,
    output logic [12:0]      tx_buffer_end_addr,
    output logic             pause_request,
    output logic [15:0]      rx_buffer_fill_bytes,
    output logic [11:0]      idle_tolerance,
    output logic             idle_tolerance_valid
);
    // =========================================
    // elaboration checks
    if (FILL_W != fbreg_pkg::OCC_W) begin : g_fill_chk
        $error("fbreg_top: FILL_W must equal 16");
    end
    if (TOL_W != fbreg_pkg::TOL_W) begin : g_tol_chk
        $error("fbreg_top: TOL_W must equal 12");
    end

    // =========================================
    // state
    logic [6:0]  rx_buffer_end_field_q;
    logic [5:0]  tx_buffer_end_field_q;
    logic [6:0]  wm_on_q;
    logic [6:0]  wm_off_q;
    logic        pause_transmit_enable_q;
    logic [11:0] idle_tolerance_gigabit_q;
    logic [11:0] idle_tolerance_fast_q;
    logic [11:0] image_gig_q;
    logic [11:0] image_fast_q;
    logic        boot_load_q;
    logic [15:0] rx_fill_q;
    logic [31:0] rx_occ_q;
    logic [31:0] tx_occ_q;
    logic        pause_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;

    // =========================================
    // helpers
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16] ? 16'hffff : s[15:0];
    endfunction

    // =========================================
    // register read images
    logic [31:0] rd_rx_end;
    logic [31:0] rd_tx_end;
    logic [31:0] rd_wmark;
    logic [31:0] rd_pause;
    logic [31:0] rd_tol;

    always_comb begin
        rd_rx_end = 32'h0000_0000;
        rd_rx_end[fbreg_pkg::RX_END_W-1:0] = rx_buffer_end_field_q;
        rd_tx_end = 32'h0000_0000;
        rd_tx_end[fbreg_pkg::TX_END_W-1:0] = tx_buffer_end_field_q;
        rd_wmark = 32'h0000_0000;
        rd_wmark[fbreg_pkg::WM_ON_LSB +: fbreg_pkg::WM_W] = wm_on_q;
        rd_wmark[fbreg_pkg::WM_OFF_LSB +: fbreg_pkg::WM_W] = wm_off_q;
        rd_pause = 32'h0000_0000;
        rd_pause[fbreg_pkg::PAUSE_EN_BIT] = pause_transmit_enable_q;
        rd_pause[fbreg_pkg::PAUSE_ST_BIT] = pause_q;
        rd_tol = 32'h0000_0000;
        rd_tol[fbreg_pkg::TOL_GIG_LSB +: fbreg_pkg::TOL_W] =
            idle_tolerance_gigabit_q;
        rd_tol[fbreg_pkg::TOL_FAST_LSB +: fbreg_pkg::TOL_W] =
            idle_tolerance_fast_q;
    end

    // =========================================
    // apb slave
    logic        acc;
    logic        commit;
    logic [31:0] rd_d;
    logic        hit_d;
    logic [31:0] wr_rx_end;
    logic [31:0] wr_tx_end;
    logic [31:0] wr_wmark;
    logic [31:0] wr_pause;
    logic [31:0] wr_tol;

    assign acc    = psel && penable && !pready_q;
    assign commit = psel && penable && pready_q && pwrite && !pslverr_q;

    assign wr_rx_end = merge(rd_rx_end, pwdata, pstrb);
    assign wr_tx_end = merge(rd_tx_end, pwdata, pstrb);
    assign wr_wmark  = merge(rd_wmark, pwdata, pstrb);
    assign wr_pause  = merge(rd_pause, pwdata, pstrb);
    assign wr_tol    = merge(rd_tol, pwdata, pstrb);

    always_comb begin
        hit_d = 1'b1;
        if (paddr == fbreg_pkg::RX_END_OFS) begin
            rd_d = rd_rx_end;
        end else if (paddr == fbreg_pkg::TX_END_OFS) begin
            rd_d = rd_tx_end;
        end else if (paddr == fbreg_pkg::WMARK_OFS) begin
            rd_d = rd_wmark;
        end else if (paddr == fbreg_pkg::RX_OCC_OFS) begin
            rd_d = rx_occ_q;
        end else if (paddr == fbreg_pkg::TX_OCC_OFS) begin
            rd_d = tx_occ_q;
        end else if (paddr == fbreg_pkg::PAUSE_OFS) begin
            rd_d = rd_pause;
        end else if (paddr == fbreg_pkg::IDLE_TOL_OFS) begin
            rd_d = rd_tol;
        end else begin
            rd_d = 32'h0000_0000;
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (acc) begin
            pready_q  <= 1'b1;
            pslverr_q <= !hit_d;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
    end

    // =========================================
    // buffer end fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_end_field_q <= fbreg_pkg::RX_END_RST;
            tx_buffer_end_field_q <= fbreg_pkg::TX_END_RST;
        end else if (commit && paddr == fbreg_pkg::RX_END_OFS) begin
            rx_buffer_end_field_q <= wr_rx_end[fbreg_pkg::RX_END_W-1:0];
        end else if (commit && paddr == fbreg_pkg::TX_END_OFS) begin
            tx_buffer_end_field_q <= wr_tx_end[fbreg_pkg::TX_END_W-1:0];
        end
    end

    // no interlock against live traffic; software halts and flushes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_end_addr <= 14'h0000;
            tx_buffer_end_addr <= 13'h0000;
        end else begin
            rx_buffer_end_addr <= {rx_buffer_end_field_q,
                                   fbreg_pkg::END_TAIL};
            tx_buffer_end_addr <= {tx_buffer_end_field_q,
                                   fbreg_pkg::END_TAIL};
        end
    end

    // =========================================
    // pause watermarks and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wm_on_q  <= fbreg_pkg::WM_RST;
            wm_off_q <= fbreg_pkg::WM_RST;
        end else if (commit && paddr == fbreg_pkg::WMARK_OFS) begin
            wm_on_q  <= wr_wmark[fbreg_pkg::WM_ON_LSB +: fbreg_pkg::WM_W];
            wm_off_q <= wr_wmark[fbreg_pkg::WM_OFF_LSB +: fbreg_pkg::WM_W];
        end
    end

    // watermarks are expected to be set before this bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_transmit_enable_q <= 1'b0;
        end else if (commit && paddr == fbreg_pkg::PAUSE_OFS) begin
            pause_transmit_enable_q <= wr_pause[fbreg_pkg::PAUSE_EN_BIT];
        end
    end

    fbreg_watermark #(
        .FILL_W (FILL_W)
    ) u_wmark (
        .pclk       (pclk),
        .presetn    (presetn),
        .enable     (pause_transmit_enable_q),
        .fill_bytes (rx_fill_q),
        .on_level   (wm_on_q),
        .off_level  (wm_off_q),
        .pause_q    (pause_q)
    );

    // =========================================
    // receive buffer fill count
    logic [15:0] frame_rounded;
    logic [15:0] frame_bytes;
    logic [15:0] fill_grown;

    assign frame_rounded = sat_add(rx_frame_len, 16'h0003) & 16'hfffc;
    assign frame_bytes   = sat_add(frame_rounded, {8'h00, rx_frame_extra});
    assign fill_grown    = rx_frame_store ? sat_add(rx_fill_q, frame_bytes)
                                          : rx_fill_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_fill_q <= 16'h0000;
        end else if (rx_buffer_flush) begin
            rx_fill_q <= 16'h0000;
        end else if (rx_drain && fill_grown < rx_drain_bytes) begin
            rx_fill_q <= 16'h0000;
        end else if (rx_drain) begin
            rx_fill_q <= fill_grown - rx_drain_bytes;
        end else begin
            rx_fill_q <= fill_grown;
        end
    end

    // =========================================
    // path occupancy status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_occ_q <= 32'h0000_0000;
            tx_occ_q <= 32'h0000_0000;
        end else begin
            rx_occ_q <= {sat_add(usb_side_rx_fill, rx_fill_q),
                         usb_side_rx_fill};
            tx_occ_q <= {sat_add(usb_side_tx_fill, tx_buffer_fill_bytes),
                         usb_side_tx_fill};
        end
    end

    // =========================================
    // latency tolerance image and fields
    logic [11:0] src_gig;
    logic [11:0] src_fast;
    logic        load_now;
    logic        restore_now;

    always_comb begin
        if (eeprom_tol_valid) begin
            src_gig  = eeprom_tol_gigabit;
            src_fast = eeprom_tol_fast;
        end else if (otp_tol_valid) begin
            src_gig  = otp_tol_gigabit;
            src_fast = otp_tol_fast;
        end else begin
            src_gig  = fbreg_pkg::TOL_RST;
            src_fast = fbreg_pkg::TOL_RST;
        end
    end

    assign load_now    = boot_load_q || nvm_load;
    assign restore_now = usb_reset || light_soft_reset;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_load_q <= 1'b1;
        end else begin
            boot_load_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image_gig_q  <= fbreg_pkg::TOL_RST;
            image_fast_q <= fbreg_pkg::TOL_RST;
        end else if (load_now) begin
            image_gig_q  <= src_gig;
            image_fast_q <= src_fast;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_tolerance_gigabit_q <= fbreg_pkg::TOL_RST;
            idle_tolerance_fast_q    <= fbreg_pkg::TOL_RST;
        end else if (load_now) begin
            idle_tolerance_gigabit_q <= src_gig;
            idle_tolerance_fast_q    <= src_fast;
        end else if (restore_now) begin
            idle_tolerance_gigabit_q <= image_gig_q;
            idle_tolerance_fast_q    <= image_fast_q;
        end else if (commit && paddr == fbreg_pkg::IDLE_TOL_OFS) begin
            idle_tolerance_gigabit_q <=
                wr_tol[fbreg_pkg::TOL_GIG_LSB +: fbreg_pkg::TOL_W];
            idle_tolerance_fast_q <=
                wr_tol[fbreg_pkg::TOL_FAST_LSB +: fbreg_pkg::TOL_W];
        end
    end

    // =========================================
    // tolerance in use while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_tolerance       <= 12'h000;
            idle_tolerance_valid <= 1'b0;
        end else if (latency_idle_state &&
                     link_speed == fbreg_pkg::FBREG_SPD_1000) begin
            idle_tolerance       <= idle_tolerance_gigabit_q;
            idle_tolerance_valid <= 1'b1;
        end else if (latency_idle_state &&
                     link_speed == fbreg_pkg::FBREG_SPD_100) begin
            idle_tolerance       <= idle_tolerance_fast_q;
            idle_tolerance_valid <= 1'b1;
        end else begin
            idle_tolerance       <= 12'h000;
            idle_tolerance_valid <= 1'b0;
        end
    end

    // =========================================
    // outputs
    assign pready               = pready_q;
    assign pslverr              = pslverr_q;
    assign prdata               = prdata_q;
    assign pause_request        = pause_q;
    assign rx_buffer_fill_bytes = rx_fill_q;
endmodule

// ### fbreg_top_tb.sv
// self-checking bench of fbreg_top over apb
// needs fbreg_pkg, fbreg_top and the bound checker
`timescale 1ns/1ps
module fbreg_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, rx_frame_store, rx_drain;
    logic        rx_buffer_flush, latency_idle_state, eeprom_tol_valid, otp_tol_valid;
    logic        nvm_load, usb_reset, light_soft_reset, pready, pslverr;
    logic        pause_request, idle_tolerance_valid;
    logic [1:0]  link_speed;
    logic [3:0]  pstrb;
    logic [7:0]  rx_frame_extra;
    logic [11:0] paddr, eeprom_tol_gigabit, eeprom_tol_fast, otp_tol_gigabit, otp_tol_fast;
    logic [11:0] idle_tolerance, eg, ef, og, oq, g2, f2;
    logic [12:0] tx_buffer_end_addr;
    logic [13:0] rx_buffer_end_addr;
    logic [15:0] rx_frame_len, rx_drain_bytes, usb_side_rx_fill, usb_side_tx_fill;
    logic [15:0] tx_buffer_fill_bytes, rx_buffer_fill_bytes, ur, fill;
    logic [31:0] pwdata, prdata;
    logic [32:0] expq [$];
    int          bad_count = 0;
    int          check_count = 0;
    int          op_k [4] = '{0, 1, 1, 0};
    int          op_b [4] = '{2045, 400, 600, 500};
    int          op_x [4] = '{3, 0, 0, 0};
    logic        op_p [4] = '{1, 1, 0, 0};

    fbreg_top #(.FILL_W(16), .TOL_W(12)) dut (.*);

    always #5 pclk = ~pclk;

    // ==========================================
    // tasks
    task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task end_sim;
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // pulse one event input for a cycle
    task automatic ev(input int k, input logic [15:0] b, input logic [7:0] x);
        @(posedge pclk);
        rx_frame_len <= b;
        rx_drain_bytes <= b;
        rx_frame_extra <= x;
        case (k)
            0: rx_frame_store <= 1'b1;
            1: rx_drain <= 1'b1;
            2: rx_buffer_flush <= 1'b1;
            3: usb_reset <= 1'b1;
            4: light_soft_reset <= 1'b1;
            default: nvm_load <= 1'b1;
        endcase
        @(posedge pclk);
        {rx_frame_store, rx_drain, rx_buffer_flush, usb_reset, light_soft_reset, nvm_load} <= '0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // ==========================================
    // read monitor
    always @(posedge pclk) begin
        if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0) begin
            cmp("read", expq.pop_front(), {pslverr, prdata});
        end
    end

    initial begin
        #100000;
        bad_count++;
        $display("BAD watchdog exp done got hang");
        end_sim;
    end

    // ==========================================
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, rx_frame_store, rx_drain, rx_buffer_flush} = '0;
        {latency_idle_state, nvm_load, usb_reset, light_soft_reset, link_speed, paddr} = '0;
        {pwdata, rx_frame_len, rx_frame_extra, rx_drain_bytes} = '0;
        pstrb = 4'hf;
        fill = 16'h0000;
        void'($urandom(32'hb496));
        {eg, ef, og, oq, g2, f2} = 72'({$urandom, $urandom, $urandom});
        ur = 16'($urandom) & 16'h7fff;
        {eeprom_tol_valid, otp_tol_valid} = 2'b11;
        {eeprom_tol_gigabit, eeprom_tol_fast, otp_tol_gigabit, otp_tol_fast} = {eg, ef, og, oq};
        usb_side_rx_fill = ur;
        usb_side_tx_fill = 16'hff00;
        tx_buffer_fill_bytes = 16'h0100 + 16'(ef);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        cmp("rx end addr", 14'h0bff, rx_buffer_end_addr);
        cmp("tx end addr", 13'h0bff, tx_buffer_end_addr);
        rd(fbreg_pkg::RX_END_OFS, 32'h0000_0017);
        rd(fbreg_pkg::TX_END_OFS, 32'h0000_0017);
        rd(fbreg_pkg::WMARK_OFS, 32'h0000_0000);
        rd(fbreg_pkg::IDLE_TOL_OFS, {4'h0, eg, 4'h0, ef});
        apb(1'b1, fbreg_pkg::RX_END_OFS, 32'hffff_ffff);
        rd(fbreg_pkg::RX_END_OFS, 32'h0000_007f);
        apb(1'b1, fbreg_pkg::TX_END_OFS, 32'hffff_ffff);
        rd(fbreg_pkg::TX_END_OFS, 32'h0000_003f);
        tick(2);
        cmp("rx end addr", 14'h3fff, rx_buffer_end_addr);
        cmp("tx end addr", 13'h1fff, tx_buffer_end_addr);
        apb(1'b1, fbreg_pkg::WMARK_OFS, 32'h0000_0204);
        apb(1'b1, fbreg_pkg::PAUSE_OFS, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            ev(op_k[i], 16'(op_b[i]), 8'(op_x[i]));
            fill = op_k[i] ? fill - 16'(op_b[i]) : fill + 16'(((op_b[i] + 3) & ~3) + op_x[i]);
            tick(2);
            cmp("rx fill", fill, rx_buffer_fill_bytes);
            cmp("pause", op_p[i], pause_request);
        end
        rd(fbreg_pkg::PAUSE_OFS, 32'h0000_0001);
        rd(fbreg_pkg::RX_OCC_OFS, {ur + fill, ur});
        apb(1'b1, fbreg_pkg::RX_OCC_OFS, 32'hffff_ffff);
        rd(fbreg_pkg::RX_OCC_OFS, {ur + fill, ur});
        rd(fbreg_pkg::TX_OCC_OFS, 32'hffff_ff00);
        @(posedge pclk);
        pstrb <= 4'b0010;
        apb(1'b1, fbreg_pkg::WMARK_OFS, 32'h0000_7f7f);
        @(posedge pclk);
        pstrb <= 4'hf;
        rd(fbreg_pkg::WMARK_OFS, 32'h0000_7f04);
        ev(2, 16'h0000, 8'h00);
        tick(2);
        cmp("rx fill", 16'h0000, rx_buffer_fill_bytes);
        apb(1'b1, fbreg_pkg::IDLE_TOL_OFS, {4'hf, g2, 4'hf, f2});
        rd(fbreg_pkg::IDLE_TOL_OFS, {4'h0, g2, 4'h0, f2});
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            latency_idle_state <= (i < 3);
            link_speed <= (i == 3) ? 2'b10 : 2'(i);
            tick(2);
            cmp("tol valid", (i == 1 || i == 2), idle_tolerance_valid);
            cmp("tol", (i == 2) ? g2 : (i == 1) ? f2 : 12'h000, idle_tolerance);
        end
        @(posedge pclk);
        eeprom_tol_gigabit <= ~eg;
        ev(3, 16'h0000, 8'h00);
        rd(fbreg_pkg::IDLE_TOL_OFS, {4'h0, eg, 4'h0, ef});
        apb(1'b1, fbreg_pkg::IDLE_TOL_OFS, {4'h0, g2, 4'h0, f2});
        ev(4, 16'h0000, 8'h00);
        rd(fbreg_pkg::IDLE_TOL_OFS, {4'h0, eg, 4'h0, ef});
        @(posedge pclk);
        eeprom_tol_valid <= 1'b0;
        ev(5, 16'h0000, 8'h00);
        rd(fbreg_pkg::IDLE_TOL_OFS, {4'h0, og, 4'h0, oq});
        @(posedge pclk);
        otp_tol_valid <= 1'b0;
        ev(5, 16'h0000, 8'h00);
        rd(fbreg_pkg::IDLE_TOL_OFS, 32'h0000_0000);
        rd(12'h0e4, 33'h1_0000_0000);
        end_sim;
    end
endmodule

// ### fbreg_watermark.sv
// pause watermark hysteresis on the receive buffer fill
// fill and thresholds come synchronous to pclk
`timescale 1ns/1ps
module fbreg_watermark #(
    parameter int FILL_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              enable,
    input  wire logic [FILL_W-1:0] fill_bytes,
    input  wire logic [6:0]        on_level,
    input  wire logic [6:0]        off_level,
    output logic                   pause_q
);
    // =========================================
    // elaboration check
    if (FILL_W != fbreg_pkg::WM_UNIT_SHIFT + fbreg_pkg::WM_W) begin : g_chk
        $error("fbreg_watermark: FILL_W must equal 16");
    end

    logic [6:0] units;
    assign units = fill_bytes[FILL_W-1:fbreg_pkg::WM_UNIT_SHIFT];

    // =========================================
    // hysteresis state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_q <= 1'b0;
        end else if (!enable) begin
            pause_q <= 1'b0;
        end else if (units >= on_level) begin
            pause_q <= 1'b1;
        end else if (units <= off_level) begin
            pause_q <= 1'b0;
        end
    end
endmodule
